/* File: tmc_adc_model.sv */
/*
 Converter model feeding the monitor inputs of the trim control.
 Assumes one 12-bit reading per cell, packed in cell order.
*/
`timescale 1ns/1ps
module tmc_adc_model
(
	input  wire logic        core_clk,
	input  wire logic [47:0] level,
	output logic [11:0]      sample,
	output logic [1:0]       channel,
	output logic             valid
);
	// Defined from time zero
	initial
	begin
		sample = 12'h000;
		channel = 2'h0;
		valid = 1'b0;
	end

	// Round robin, a sample every other cycle
	always @(posedge core_clk)
	begin
		valid <= ~valid;
		if (valid)
		begin
			channel <= channel + 2'h1;
			sample <= ~sample; // Stale data never left standing
		end
		else
			sample <= level[channel * 12 +: 12];
	end
endmodule

/* File: tmc_pkg.sv */
/*
 Shared constants for the four-cell trim and margin control block:
 widths, reset codes, update-interval timing and mode encodings.
 Assumes a 40 MHz core clock; all counts are derived from it.
*/
package tmc_pkg;

	localparam int          NUM_CELLS     = 4;
	localparam int          DAC_W         = 8;
	localparam int          SETP_W        = 12;
	localparam int          CLK_MHZ       = 40;

	// Bipolar zero of the trim DAC
	localparam logic [7:0]  DAC_MID       = 8'h80;
	localparam logic [7:0]  DAC_MIN       = 8'h00;
	localparam logic [7:0]  DAC_MAX       = 8'hff;

	// Mode bit: 0 = closed-loop calculator (default), 1 = manual
	localparam logic        MODE_CALC     = 1'b0;
	localparam logic        MODE_MANUAL   = 1'b1;

	// Update interval select codes
	localparam logic [1:0]  RATE_860US    = 2'h0;
	localparam logic [1:0]  RATE_1720US   = 2'h1;
	localparam logic [1:0]  RATE_13800US  = 2'h2;
	localparam logic [1:0]  RATE_27600US  = 2'h3;

	// Interval times in ns
	localparam longint      T_860US_NS    = 860000;
	localparam longint      T_1720US_NS   = 1720000;
	localparam longint      T_13800US_NS  = 13800000;
	localparam longint      T_27600US_NS  = 27600000;

	// Cycle counts, rounded down (longest interval between updates)
	localparam longint      CYC_860US     = T_860US_NS * CLK_MHZ / 1000;
	localparam longint      CYC_1720US    = T_1720US_NS * CLK_MHZ / 1000;
	localparam longint      CYC_13800US   = T_13800US_NS * CLK_MHZ / 1000;
	localparam longint      CYC_27600US   = T_27600US_NS * CLK_MHZ / 1000;

	localparam int          TICK_W        = 21;

	// Profile index after decode
	localparam logic [1:0]  PROF_0        = 2'h0;
	localparam logic [1:0]  PROF_1        = 2'h1;
	localparam logic [1:0]  PROF_2        = 2'h2;

endpackage

/* File: tmc_props.sv */
/*
 Checker for the trim control top, watching cells 0 and 1.
 Assumes the cell configuration stays static while it runs.
*/
`timescale 1ns/1ps
module tmc_props
(
	input wire logic        core_clk,
	input wire logic        rst,
	input wire logic [3:0]  cfg_mode,
	input wire logic [3:0]  cfg_polarity,
	input wire logic [31:0] cfg_code_p1,
	input wire logic [47:0] cfg_setp_p2,
	input wire logic [3:0]  profile_select_lo,
	input wire logic [3:0]  profile_select_hi,
	input wire logic [3:0]  closed_loop_enable,
	input wire logic [3:0]  trim_output_enable,
	input wire logic [11:0] voltage_monitor_input,
	input wire logic [1:0]  monitor_channel,
	input wire logic        monitor_valid,
	input wire logic        analog_power_up_done,
	input wire logic [31:0] dac_code,
	input wire logic [3:0]  dac_drive_en,
	input wire logic [47:0] setpoint
);
	// Per-cell views; cell 0 is the closed-loop one
	wire [1:0] sel0  = {profile_select_hi[0], profile_select_lo[0]};
	wire [1:0] sel1  = {profile_select_hi[1], profile_select_lo[1]};
	wire       calc0 = cfg_mode[0] == tmc_pkg::MODE_CALC;
	wire       smp0  = calc0 && monitor_valid && monitor_channel == 2'h0;
	wire [7:0] d0    = dac_code[7:0];

	default clocking @(posedge core_clk);
	endclocking
	default disable iff (rst);

	// Select change taken once the link is live
	sequence s_sel0;
		analog_power_up_done && $changed(sel0);
	endsequence
	sequence s_sel1;
		analog_power_up_done && $changed(sel1);
	endsequence

	a_reset_state: assert property (disable iff (1'b0)
		rst |=> !dac_drive_en && !analog_power_up_done
		&& (!calc0 || d0 == tmc_pkg::DAC_MID))
		else $error("reset state wrong");
	a_done_stays: assert property (
		analog_power_up_done |=> analog_power_up_done)
		else $error("power-up done fell");
	a_drive_follows: assert property (
		analog_power_up_done |=> dac_drive_en == $past(trim_output_enable))
		else $error("drive enable wrong");
	a_manual_load: assert property (
		s_sel1 ##0 (cfg_mode[1] && sel1 == 2'h1)
		|=> dac_code[15:8] == $past(cfg_code_p1[15:8]))
		else $error("manual code not loaded");
	a_setp_three: assert property (
		s_sel0 ##0 sel0 == 2'h3
		|=> setpoint[11:0] == $past(cfg_setp_p2[11:0]))
		else $error("setpoint not from profile 2");
	a_calc_step: assert property (
		calc0 |=> d0 == $past(d0) || d0 == $past(d0) + 8'h01
		|| d0 == $past(d0) - 8'h01)
		else $error("step larger than one");
	a_no_wrap: assert property (
		calc0 && (d0 == 8'hff || d0 == 8'h00) |=> d0 != ~$past(d0))
		else $error("dac wrapped");
	a_hold_off: assert property (
		calc0 && !closed_loop_enable[0] |=> $stable(d0))
		else $error("dac moved with loop off");
	a_needs_sample: assert property (
		calc0 && !smp0 |=> $stable(d0))
		else $error("dac moved without sample");
	a_step_dir: assert property (
		smp0 && closed_loop_enable[0] && !cfg_polarity[0]
		&& setpoint[11:0] > voltage_monitor_input |=> d0 >= $past(d0))
		else $error("dac stepped wrong way");
	a_equal_hold: assert property (
		smp0 && setpoint[11:0] == voltage_monitor_input |=> $stable(d0))
		else $error("dac moved on equal");
endmodule

bind tmc_trim_control tmc_props u_props (.core_clk, .rst, .cfg_mode,
	.cfg_polarity, .cfg_code_p1, .cfg_setp_p2, .profile_select_lo,
	.profile_select_hi, .closed_loop_enable, .trim_output_enable,
	.voltage_monitor_input, .monitor_channel, .monitor_valid,
	.analog_power_up_done, .dac_code, .dac_drive_en, .setpoint);

/* File: tmc_trim_cell.sv */
/*
 One trim cell: profile storage, setpoint register, three-state
 comparator and saturating DAC register, with output enable.
 Assumes monitor readings are 12-bit, aligned with setpoints, and
 that the update tick is shared among all cells.
*/
`timescale 1ns/1ps
module tmc_trim_cell
(
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        cfg_mode,
	input  wire logic        cfg_polarity,
	input  wire logic [7:0]  cfg_code_p1,
	input  wire logic [7:0]  cfg_code_p2,
	input  wire logic [7:0]  cfg_code_p0_init,
	input  wire logic [11:0] cfg_setp_p1,
	input  wire logic [11:0] cfg_setp_p2,
	input  wire logic [11:0] cfg_setp_p0_init,
	input  wire logic        write_protect,
	input  wire logic        host_code_we,
	input  wire logic [7:0]  host_code,
	input  wire logic        host_setp_we,
	input  wire logic [11:0] host_setp,
	input  wire logic        link_ready,
	input  wire logic        profile_select_lo,
	input  wire logic        profile_select_hi,
	input  wire logic        closed_loop_enable,
	input  wire logic        trim_output_enable,
	input  wire logic [11:0] voltage_monitor_input,
	input  wire logic        monitor_valid,
	input  wire logic        update_tick,
	output logic [7:0]       dac_code,
	output logic             dac_drive_en,
	output logic [11:0]      setpoint
);

	logic [7:0]  code_p0_q;
	logic [11:0] setp_p0_q;
	logic [11:0] setp_q;
	logic [7:0]  dac_q;
	logic [1:0]  sel_q;
	logic        first_q;
	logic        upd_pend_q;
	logic [1:0]  sel;
	logic        sel_change;
	logic [7:0]  sel_code;
	logic [11:0] sel_setp;
	logic        step_up;
	logic        step_dn;
	logic        raise;
	logic        lower;
	logic        cl_run;

	// Binary profile index, code 11 folds onto profile 2
	assign sel = {profile_select_hi, profile_select_lo} == 2'h3 ?
		tmc_pkg::PROF_2 : {profile_select_hi, profile_select_lo};

	// Inputs from the link are ignored until power-up completes
	assign sel_change = link_ready && (first_q || sel != sel_q);

	always_comb
	begin
		unique case (sel)
			tmc_pkg::PROF_0: sel_code = code_p0_q;
			tmc_pkg::PROF_1: sel_code = cfg_code_p1;
			default:         sel_code = cfg_code_p2;
		endcase
	end

	always_comb
	begin
		unique case (sel)
			tmc_pkg::PROF_0: sel_setp = setp_p0_q;
			tmc_pkg::PROF_1: sel_setp = cfg_setp_p1;
			default:         sel_setp = cfg_setp_p2;
		endcase
	end

	// Last seen selection, for change detection
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			sel_q   <= tmc_pkg::PROF_0;
			first_q <= 1'b1;
		end
		else if (link_ready)
		begin
			sel_q   <= sel;
			first_q <= 1'b0;
		end
	end

	// Run-time profile 0 overwrite, blocked by write protection
	always_ff @(posedge core_clk)
	begin
		if (rst)
			code_p0_q <= cfg_code_p0_init;
		else if (host_code_we && !write_protect)
			code_p0_q <= host_code;
	end

	// Profile 0 setpoint doubles as the VID setpoint
	always_ff @(posedge core_clk)
	begin
		if (rst)
			setp_p0_q <= cfg_setp_p0_init;
		else if (host_setp_we && !write_protect)
			setp_p0_q <= host_setp;
	end

	// Setpoint register reloads on selection change
	always_ff @(posedge core_clk)
	begin
		if (rst)
			setp_q <= cfg_setp_p0_init;
		else if (sel_change)
			setp_q <= sel_setp;
	end

	// Three-state compare with channel polarity
	assign step_up = setp_q > voltage_monitor_input;
	assign step_dn = setp_q < voltage_monitor_input;
	assign raise   = cfg_polarity ? step_dn : step_up;
	assign lower   = cfg_polarity ? step_up : step_dn;
	assign cl_run  = cfg_mode == tmc_pkg::MODE_CALC && link_ready &&
		closed_loop_enable && trim_output_enable;

	// Tick waits for a fresh monitor sample before acting
	always_ff @(posedge core_clk)
	begin
		if (rst || !cl_run)
			upd_pend_q <= 1'b0;
		else if (update_tick)
			upd_pend_q <= 1'b1;
		else if (monitor_valid)
			upd_pend_q <= 1'b0;
	end

	// DAC register: manual profile load or closed-loop stepping
	always_ff @(posedge core_clk)
	begin
		if (rst)
			dac_q <= cfg_mode == tmc_pkg::MODE_MANUAL ?
				cfg_code_p0_init : tmc_pkg::DAC_MID;
		else if (cfg_mode == tmc_pkg::MODE_MANUAL)
		begin
			if (sel_change)
				dac_q <= sel_code;
		end
		else if (cl_run && upd_pend_q && monitor_valid)
		begin
			if (raise && dac_q != tmc_pkg::DAC_MAX)
				dac_q <= dac_q + 8'h01;
			else if (lower && dac_q != tmc_pkg::DAC_MIN)
				dac_q <= dac_q - 8'h01;
		end
		// Otherwise hold the last update
	end

	// Output enable gates the pin driver in every mode
	always_ff @(posedge core_clk)
	begin
		if (rst)
			dac_drive_en <= 1'b0;
		else
			dac_drive_en <= link_ready && trim_output_enable;
	end

	assign dac_code = dac_q;
	assign setpoint = setp_q;

endmodule

/* File: tmc_trim_control.sv */
/*
 Top of the four-cell trim and margin control. Per-cell configuration
 (mode, polarity, profiles) comes as plain ports standing for the
 non-volatile store; host writes arrive as strobes from the serial
 interface. Assumes monitor readings arrive in cell order with a
 valid strobe and cell index from the shared converter.
*/
// Behaviour
// - Four trim cells, each enabled and controlled on its own.
// - Stored mode bit picks stored codes or closed-loop for DAC.
// - Two select inputs per cell pick its active profile.
// - Manual mode applies one of three stored 8-bit codes directly.
// - Manual DAC reloads whenever the decoded profile changes (codes 10 and 11 both pick profile 2).
// - Host may overwrite profile 0 code unless write-protected.
// - Setpoint register reloads from selected 12-bit profile on change.
// - Host may overwrite profile 0 setpoint unless write-protected.
// - Compare setpoint to monitor, adjust DAC, gated by loop enable.
// - Monitor readings from shared converter feed the loop.
// - Loop enable high starts closed-loop trimming for that cell; code also needs output enable high.
// - Output enable low floats the pin; high drives the DAC value.
// - Loop enable low holds last DAC value; reset value 80h.
// - Both enables high update the DAC from the monitor.
// - VID host writes share profile 0 setpoint, same protection.
// - Signal power-up done; link then takes control of outputs.
// - Step DAC by comparison sign and polarity; hold when equal.
// - One shared rate sets interval: 860us, 1.72ms, 13.8ms, 27.6ms.
// - Reset: output off, loop off, profile 0 setpoint, DAC by mode.
// - Each cell uses its own same-numbered monitor input.
`timescale 1ns/1ps
module tmc_trim_control #(
	parameter logic [20:0] CYC_A = 21'(tmc_pkg::CYC_860US),
	parameter logic [20:0] CYC_B = 21'(tmc_pkg::CYC_1720US),
	parameter logic [20:0] CYC_C = 21'(tmc_pkg::CYC_13800US),
	parameter logic [20:0] CYC_D = 21'(tmc_pkg::CYC_27600US),
	parameter logic [7:0]  PWRUP_CYC = 8'h10
)
(
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic [3:0]  cfg_mode,
	input  wire logic [3:0]  cfg_polarity,
	input  wire logic [1:0]  cfg_update_rate,
	input  wire logic        cfg_write_protect,
	input  wire logic [31:0] cfg_code_p0,
	input  wire logic [31:0] cfg_code_p1,
	input  wire logic [31:0] cfg_code_p2,
	input  wire logic [47:0] cfg_setp_p0,
	input  wire logic [47:0] cfg_setp_p1,
	input  wire logic [47:0] cfg_setp_p2,
	input  wire logic        host_code_we,
	input  wire logic        host_setp_we,
	input  wire logic [1:0]  host_cell,
	input  wire logic [11:0] host_data,
	input  wire logic [3:0]  profile_select_lo,
	input  wire logic [3:0]  profile_select_hi,
	input  wire logic [3:0]  closed_loop_enable,
	input  wire logic [3:0]  trim_output_enable,
	input  wire logic [11:0] voltage_monitor_input,
	input  wire logic [1:0]  monitor_channel,
	input  wire logic        monitor_valid,
	output logic             analog_power_up_done,
	output logic [31:0]      dac_code,
	output logic [3:0]       dac_drive_en,
	output logic [47:0]      setpoint
);

	logic       tick;
	logic [7:0] pwr_cnt_q;
	logic       done_q;

	// Power-up sequence: short settle count, then hand over to link
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			pwr_cnt_q <= 8'h00;
			done_q    <= 1'b0;
		end
		else if (pwr_cnt_q != PWRUP_CYC)
			pwr_cnt_q <= pwr_cnt_q + 8'h01;
		else
			done_q <= 1'b1;
	end

	assign analog_power_up_done = done_q;

	// One interval timer shared by all cells
	tmc_update_timer #(
		.CYC_A (CYC_A),
		.CYC_B (CYC_B),
		.CYC_C (CYC_C),
		.CYC_D (CYC_D)
	) u_timer (
		.core_clk (core_clk),
		.rst      (rst),
		.rate_sel (cfg_update_rate),
		.tick     (tick)
	);

	// Four independent cells, each fed only its own monitor channel
	for (genvar i = 0; i < tmc_pkg::NUM_CELLS; i++)
	begin : g_cell
		tmc_trim_cell u_cell (
			.core_clk              (core_clk),
			.rst                   (rst),
			.cfg_mode              (cfg_mode[i]),
			.cfg_polarity          (cfg_polarity[i]),
			.cfg_code_p1           (cfg_code_p1[i*8 +: 8]),
			.cfg_code_p2           (cfg_code_p2[i*8 +: 8]),
			.cfg_code_p0_init      (cfg_code_p0[i*8 +: 8]),
			.cfg_setp_p1           (cfg_setp_p1[i*12 +: 12]),
			.cfg_setp_p2           (cfg_setp_p2[i*12 +: 12]),
			.cfg_setp_p0_init      (cfg_setp_p0[i*12 +: 12]),
			.write_protect         (cfg_write_protect),
			.host_code_we          (host_code_we &&
				host_cell == 2'(i)),
			.host_code             (host_data[7:0]),
			.host_setp_we          (host_setp_we &&
				host_cell == 2'(i)),
			.host_setp             (host_data),
			.link_ready            (done_q),
			.profile_select_lo     (profile_select_lo[i]),
			.profile_select_hi     (profile_select_hi[i]),
			.closed_loop_enable    (closed_loop_enable[i]),
			.trim_output_enable    (trim_output_enable[i]),
			.voltage_monitor_input (voltage_monitor_input),
			.monitor_valid         (monitor_valid &&
				monitor_channel == 2'(i)),
			.update_tick           (tick),
			.dac_code              (dac_code[i*8 +: 8]),
			.dac_drive_en          (dac_drive_en[i]),
			.setpoint              (setpoint[i*12 +: 12])
		);
	end

endmodule

/* File: tmc_update_timer.sv */
/*
 Shared update-rate timer: emits a one-cycle tick at the chosen
 closed-loop correction interval. Interval counts are parameters so
 simulation can shrink them; rate select is a static configuration.
*/
`timescale 1ns/1ps
module tmc_update_timer #(
	parameter logic [20:0] CYC_A = 21'(tmc_pkg::CYC_860US),
	parameter logic [20:0] CYC_B = 21'(tmc_pkg::CYC_1720US),
	parameter logic [20:0] CYC_C = 21'(tmc_pkg::CYC_13800US),
	parameter logic [20:0] CYC_D = 21'(tmc_pkg::CYC_27600US)
)
(
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic [1:0] rate_sel,
	output logic            tick
);

	logic [20:0] cnt_q;
	logic [20:0] limit;

	// Terminal count for the selected interval
	always_comb
	begin
		unique case (rate_sel)
			tmc_pkg::RATE_860US:   limit = CYC_A;
			tmc_pkg::RATE_1720US:  limit = CYC_B;
			tmc_pkg::RATE_13800US: limit = CYC_C;
			default:               limit = CYC_D;
		endcase
	end

	assign tick = (cnt_q >= limit - 21'h000001);

	// Free-running interval counter, restarts on each tick
	always_ff @(posedge core_clk)
	begin
		if (rst || tick)
			cnt_q <= 21'h000000;
		else
			cnt_q <= cnt_q + 21'h000001;
	end

endmodule

/* File: trim_margin_cell_control_bench.sv */
/*
 Self-checking bench for the trim control top: link, host writes and
 closed loop. Assumes the converter model and checker compile first.
*/
`timescale 1ns/1ps
module trim_margin_cell_control_bench;
	logic        core_clk = 0;
	logic        rst = 1;
	logic [3:0]  cfg_mode = 4'ha;
	logic [3:0]  cfg_polarity = 4'h4;
	logic [1:0]  cfg_update_rate = 2'h0;
	logic        cfg_write_protect = 0;
	logic [31:0] cfg_code_p0, cfg_code_p1, cfg_code_p2, c0, dac_code;
	logic [47:0] cfg_setp_p0, cfg_setp_p1, cfg_setp_p2, s0, setpoint;
	logic        host_code_we = 0, host_setp_we = 0;
	logic [1:0]  host_cell = 0, monitor_channel;
	logic [11:0] host_data = 0, voltage_monitor_input;
	logic [3:0]  profile_select_lo = 0, profile_select_hi = 0, oe;
	logic [3:0]  closed_loop_enable = 0, trim_output_enable = 0;
	logic [3:0]  dac_drive_en;
	logic        monitor_valid, analog_power_up_done;
	logic [47:0] level = '0;
	logic [84:0] q[$];
	int          n_fail = 0, samples_checked = 0, cyc = 0;
	event        ev;

	always #12.5 core_clk = ~core_clk;

	tmc_trim_control #(.CYC_A(21'h14), .CYC_B(21'h28), .CYC_C(21'h50),
		.CYC_D(21'ha0)) DUT (.core_clk, .rst, .cfg_mode, .cfg_polarity,
		.cfg_update_rate, .cfg_write_protect, .cfg_code_p0, .cfg_code_p1,
		.cfg_code_p2, .cfg_setp_p0, .cfg_setp_p1, .cfg_setp_p2,
		.host_code_we, .host_setp_we, .host_cell, .host_data,
		.profile_select_lo, .profile_select_hi, .closed_loop_enable,
		.trim_output_enable, .voltage_monitor_input, .monitor_channel,
		.monitor_valid, .analog_power_up_done, .dac_code, .dac_drive_en,
		.setpoint);

	tmc_adc_model ADC (.core_clk, .level, .sample(voltage_monitor_input),
		.channel(monitor_channel), .valid(monitor_valid));

	task automatic check(logic [84:0] seen, logic [84:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("mismatch outputs exp %h seen %h", exp, seen);
		end
	endtask

	task automatic stop_test();
		$display("checked %0d failed %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Expectation noted when outputs have settled
	task automatic note(logic [84:0] e);
		@(negedge core_clk);
		q.push_back(e);
		->ev;
	endtask

	task automatic host(logic c, logic [1:0] cl, logic [11:0] d, logic p);
		@(posedge core_clk);
		cfg_write_protect <= p;
		host_code_we <= c;
		host_setp_we <= !c;
		host_cell <= cl;
		host_data <= d;
		@(posedge core_clk);
		host_code_we <= 0;
		host_setp_we <= 0;
	endtask

	task automatic link(logic [1:0] s, logic [3:0] e, logic [3:0] cl);
		@(posedge core_clk);
		profile_select_lo <= {4{s[0]}};
		profile_select_hi <= {4{s[1]}};
		trim_output_enable <= e;
		closed_loop_enable <= cl;
	endtask

	// Outputs with profile i active; calculator cells idle at mid
	function automatic logic [84:0] want(int i);
		logic [31:0] c;
		logic [47:0] s;
		c = i == 0 ? c0 : i == 1 ? cfg_code_p1 : cfg_code_p2;
		s = i == 0 ? s0 : i == 1 ? cfg_setp_p1 : cfg_setp_p2;
		return {1'b1, oe, s, c[31:24], 8'h80, c[15:8], 8'h80};
	endfunction

	// Oldest note against the outputs as they stand
	always @(ev)
		check({analog_power_up_done, dac_drive_en, setpoint, dac_code},
			q.pop_front());

	// Hang guard, well above the planned run
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 25000)
		begin
			n_fail++;
			stop_test();
		end
	end

	initial
	begin
		void'($urandom(32));
		cfg_update_rate = 2'($urandom()); // Any interval code
		cfg_code_p0 = $urandom();
		cfg_code_p1 = $urandom();
		cfg_code_p2 = $urandom();
		cfg_setp_p0 = 48'({$urandom(), $urandom()}) | 48'h001001001001;
		cfg_setp_p1 = 48'({$urandom(), $urandom()});
		cfg_setp_p2 = 48'({$urandom(), $urandom()});
		c0 = cfg_code_p0;
		s0 = cfg_setp_p0;
		oe = 4'h0;
		repeat (12) @(posedge core_clk);
		rst <= 0;
		note({5'h00, s0, c0[31:24], 8'h80, c0[15:8], 8'h80});
		for (int k = 0; k < 40 && analog_power_up_done !== 1'b1; k++)
			@(negedge core_clk);
		note(want(0));
		host(1, 2'h1, 12'h0a5, 1);
		host(1, 2'h3, 12'h03c, 0);
		host(0, 2'h0, 12'h7e1, 0);
		note(want(0));
		c0[31:24] = 8'h3c;
		s0[11:0] = 12'h7e1;
		// Selects 1, 2, 3 then back to 0 with random drive enables
		for (int j = 1; j < 5; j++)
		begin
			oe = 4'($urandom());
			link(2'(j), oe, 4'h0);
			repeat (2) @(posedge core_clk);
			note(want(j % 4 == 3 ? 2 : j % 4));
		end
		oe = 4'hf;
		link(2'h0, oe, 4'hf);
		// Worst ramp is 128 steps, one per interval of 20 << rate
		repeat ((135 * 20) << cfg_update_rate) @(posedge core_clk);
		note(want(0) & ~85'hff00ff | 85'hff);
		link(2'h0, oe, 4'h0);
		level <= 48'hfff_fff_fff_fff;
		repeat (200) @(posedge core_clk);
		note(want(0) & ~85'hff00ff | 85'hff);
		link(2'h0, oe, 4'hf);
		level <= s0;
		repeat (200) @(posedge core_clk);
		note(want(0) & ~85'hff00ff | 85'hff);
		// Mid-run reset drops loop state and host writes
		@(posedge core_clk);
		rst <= 1;
		repeat (2) @(posedge core_clk);
		rst <= 0;
		c0 = cfg_code_p0 & 32'hff00ff00 | 32'h00800080;
		note({5'h00, cfg_setp_p0, c0});
		stop_test();
	end
endmodule
